/* src/sfn_flag.sv */
// How it works
// (R1) Control bit 3 clear, bit 2 set: flag acts as split transfer request.
// (R2) Split mode: flag rising during blanking gives one extra shift clock cycle.
// (R3) Bit 3 set, bit 2 clear: half-byte mode, flag sampled at video clock fall.
// (R4) Sampled high picks upper nibble at next shift rise; low picks lower nibble.
// (R5) Both bits clear: flag input ignored.
// (R6) Controller must never set bits 3 and 2 together.
// (R7) Drive a programmable video clock output for the graphics processor.
// (R8) Shift clock is a selectable integer submultiple of the dot clock.
// (R9) Shift clock suppressed during blanking except the inserted split pulse.
// (R10) Flag synchronised and edge-detected; at most one extra cycle per rise.
`default_nettype none
module sfn_flag
	import sfn_pkg::*;
#(
	parameter int W  = DIV_W,
	parameter int PW = PIX_W
) (
	// Dot clock and reset
	input  wire logic          CLK,
	input  wire logic          RST_B,
	// General control bits 3 and 2
	input  wire logic [3:2]    GEN_CTRL,
	// Divider ratios
	input  wire logic [W-1:0]  SHIFT_DIV,
	input  wire logic [W-1:0]  VIDEO_DIV,
	// Pins
	input  wire logic          BLANK_B,
	input  wire logic          TRANSFER_OR_HALF_BYTE_FLAG,
	input  wire logic [PW-1:0] PIX_IN,
	// Clocks out
	output var  logic          SHIFT_CLK,
	output var  logic          VIDEO_CLOCK_OUTPUT,
	// Latched pixel data and nibble select; decoded bad-mode flag
	output var  logic [PW-1:0] PIX_OUT,
	output var  logic          PIX_VALID,
	output var  logic          HALF_SEL,
	output var  logic          MODE_BAD
);
	// Three-stage synchronisers; stage one feeds stage two only
	logic [2:0]      flag_sync_q;
	logic [2:0]      blank_sync_q;
	logic            flag_q;
	logic            blanking_q;
	logic            flag_rise;
	sfn_role_t       role;
	logic            split_en;
	logic            nib_en;
	logic            extra_pend_q;
	logic            extra_pend_d;
	logic            extra_run_q;
	logic            extra_run_d;
	logic            start_extra;
	logic            sdiv_hold;
	logic            s_level;
	logic            s_rise;
	logic            v_rise;
	logic            v_fall;
	logic            v_level;
	logic            half_q;
	logic            half_d;
	logic [PW-1:0]   pix_q;
	logic [PW-1:0]   pix_d;
	logic            pv_q;
	logic            shift_q;
	logic            sdiv_fall;

	function automatic logic [PW-1:0] nibble_pick(input logic [PW-1:0] d, input logic hi);
		logic [PW-1:0] r;
		r = '0;
		for (int i = 0; i < PW / 8; i++) begin
			r[i*8 +: 4] = hi ? d[i*8+4 +: 4] : d[i*8 +: 4];
		end
		return r;
	endfunction

	// Role decode; the both-set code is flagged and treated as off
	assign role = sfn_role_t'({GEN_CTRL[GC_ROLE_HI_BIT], GEN_CTRL[GC_ROLE_LO_BIT]});
	assign split_en = (role == SFN_ROLE_SPLIT); // (R1)
	assign nib_en   = (role == SFN_ROLE_NIBBLE); // (R3)
	assign MODE_BAD = (role == SFN_ROLE_BAD); // (R6)

	// Change counts when stages two and three agree
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			flag_sync_q  <= 3'h0;
			blank_sync_q <= 3'h0;
			flag_q       <= 1'b0;
			blanking_q   <= 1'b1;
		end else begin
			flag_sync_q  <= {flag_sync_q[1:0], TRANSFER_OR_HALF_BYTE_FLAG}; // (R10)
			blank_sync_q <= {blank_sync_q[1:0], BLANK_B};
			if (flag_sync_q[1] == flag_sync_q[2])
				flag_q <= flag_sync_q[2];
			if (blank_sync_q[1] == blank_sync_q[2])
				blanking_q <= !blank_sync_q[2];
		end
	end

	// Off role ignores the flag completely
	assign flag_rise = (flag_sync_q[1] == flag_sync_q[2]) && flag_sync_q[2] && !flag_q; // (R5)

	// One pending request per rise; a second rise while pending merges into it
	assign start_extra  = extra_pend_q && !extra_run_q && !s_level;
	assign extra_pend_d = split_en && blanking_q && (flag_rise || (extra_pend_q && !start_extra)); // (R2) (R10)
	// Extra cycle lasts one full high phase, ending at the divider's fall
	assign extra_run_d  = start_extra || (extra_run_q && !sdiv_fall);

	// Divider held in blanking so shift clock stays low, except the extra cycle
	assign sdiv_hold = blanking_q && !extra_run_q && !start_extra; // (R9)

	sfn_clkdiv #(
		.W (W)
	) u_sdiv (
		.clk   (CLK),
		.rst_b (RST_B),
		.ratio (SHIFT_DIV), // (R8)
		.hold  (sdiv_hold),
		.level (s_level),
		.rise  (s_rise),
		.fall  (sdiv_fall)
	);

	sfn_clkdiv #(
		.W (W)
	) u_vdiv (
		.clk   (CLK),
		.rst_b (RST_B),
		.ratio (VIDEO_DIV), // (R7)
		.hold  (1'b0),
		.level (v_level),
		.rise  (v_rise),
		.fall  (v_fall)
	);

	// Nibble select sampled at video clock fall
	assign half_d = (nib_en && v_fall) ? flag_q : half_q; // (R3)
	// Latch on each shift rise; whole bytes outside half-byte mode
	assign pix_d  = s_rise ? (nib_en ? nibble_pick(PIX_IN, half_q) : PIX_IN) : pix_q; // (R4)

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			extra_pend_q <= 1'b0;
			extra_run_q  <= 1'b0;
			half_q       <= HALF_SEL_RST;
			pix_q        <= '0;
			pv_q         <= 1'b0;
			shift_q      <= 1'b0;
			VIDEO_CLOCK_OUTPUT <= 1'b0;
		end else begin
			extra_pend_q <= extra_pend_d;
			extra_run_q  <= extra_run_d;
			half_q       <= half_d;
			pix_q        <= pix_d;
			pv_q         <= s_rise;
			shift_q      <= s_level;
			VIDEO_CLOCK_OUTPUT <= v_level; // (R7)
		end
	end

	assign SHIFT_CLK = shift_q;
	assign PIX_OUT   = pix_q;
	assign PIX_VALID = pv_q;
	assign HALF_SEL  = half_q;
endmodule
`default_nettype wire

/* src/sfn_pkg.sv */
`default_nettype none
package sfn_pkg;
	// General control register bit positions for the flag role
	localparam int GC_ROLE_HI_BIT = 3;
	localparam int GC_ROLE_LO_BIT = 2;
	// Flag roles decoded from the two control bits
	typedef enum logic [1:0] {
		SFN_ROLE_OFF,
		SFN_ROLE_SPLIT,
		SFN_ROLE_NIBBLE,
		SFN_ROLE_BAD
	} sfn_role_t;
	// Divider and pixel widths, divider defaults and reset values
	localparam int          DIV_W           = 4;
	localparam logic [3:0]  SHIFT_DIV_RST   = 4'h4;
	localparam logic [3:0]  VIDEO_DIV_RST   = 4'h8;
	localparam int          PIX_W           = 32;
	localparam logic        HALF_SEL_RST    = 1'b0;
endpackage
`default_nettype wire

/* src/sfn_clkdiv.sv */
`default_nettype none
// Integer divider, parked while hold is set, square output plus one-cycle rise and fall enables
module sfn_clkdiv
	import sfn_pkg::*;
#(
	parameter int W = DIV_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Control
	input  wire logic [W-1:0] ratio,
	input  wire logic         hold,
	// Outputs
	output var  logic         level,
	output var  logic         rise,
	output var  logic         fall
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         lvl_q;
	logic         lvl_d;
	logic [W-1:0] half;
	logic [W-1:0] top;
	logic         wrap;

	// Ratio below two behaves as two; odd ratios round the high phase down
	assign top   = (ratio < W'(2)) ? W'(1) : ratio - W'(1);
	assign half  = (ratio < W'(2)) ? W'(1) : ratio >> 1;
	assign wrap  = (cnt_q == top);
	// Parked at all ones, so the first count after a hold or reset wraps to zero
	// and the first high phase is as long as every later one
	assign cnt_d = hold ? '1 : (wrap ? '0 : cnt_q + W'(1));
	assign lvl_d = hold ? 1'b0 : (cnt_d < half);
	assign rise  = !lvl_q && lvl_d;
	assign fall  = lvl_q && !lvl_d;
	assign level = lvl_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '1;
			lvl_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			lvl_q <= lvl_d;
		end
	end
endmodule
`default_nettype wire

/* testbench/sfn_flag_properties.sv */
`default_nettype none
module sfn_flag_properties #(parameter int W = 4, parameter int PW = 32) (
	// Clock, reset, control
	input wire logic          CLK, RST_B, BLANK_B, TRANSFER_OR_HALF_BYTE_FLAG,
	input wire logic [3:2]    GEN_CTRL,
	input wire logic [W-1:0]  SHIFT_DIV, VIDEO_DIV,
	// Pixel and outputs
	input wire logic [PW-1:0] PIX_IN, PIX_OUT,
	input wire logic          SHIFT_CLK, VIDEO_CLOCK_OUTPUT, PIX_VALID, HALF_SEL, MODE_BAD
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Blank held long enough to be synced before the flag rises
	sequence s_req;
		(GEN_CTRL == 2'b01 && !BLANK_B) [*4] ##0 $rose(TRANSFER_OR_HALF_BYTE_FLAG);
	endsequence
	sequence s_pulse;
		SHIFT_CLK [*2] ##1 !SHIFT_CLK;
	endsequence
	property p_split; s_req |-> ##[1:8] SHIFT_CLK; endproperty
	a_split: assert property (p_split) else $error("no extra shift pulse");
	property p_once; $fell(SHIFT_CLK) && !BLANK_B && TRANSFER_OR_HALF_BYTE_FLAG |=> !SHIFT_CLK [*8]; endproperty
	a_once: assert property (p_once) else $error("second extra pulse");
	property p_shift; $rose(SHIFT_CLK) && SHIFT_DIV == 4'h4 && BLANK_B |-> s_pulse; endproperty
	a_shift: assert property (p_shift) else $error("shift high phase wrong");
	property p_video_clock_output; $rose(VIDEO_CLOCK_OUTPUT) && VIDEO_DIV == 4'h8 |-> VIDEO_CLOCK_OUTPUT [*4] ##1 !VIDEO_CLOCK_OUTPUT; endproperty
	a_video_clock_output: assert property (p_video_clock_output) else $error("video clock phase wrong");
	property p_blank; (!BLANK_B && GEN_CTRL == 2'b00) [*8] |-> !SHIFT_CLK; endproperty
	a_blank: assert property (p_blank) else $error("shift clock during blank");
	property p_bad; MODE_BAD == (GEN_CTRL == 2'b11); endproperty
	a_bad: assert property (p_bad) else $error("bad mode flag wrong");
	property p_half; $changed(HALF_SEL) |-> GEN_CTRL[3] || $past(GEN_CTRL[3]); endproperty
	a_half: assert property (p_half) else $error("nibble select moved");
	property p_pix; PIX_VALID && GEN_CTRL == 2'b10 |-> (PIX_OUT & 32'hF0F0F0F0) == 32'h0; endproperty
	a_pix: assert property (p_pix) else $error("nibble packing wrong");
endmodule
bind sfn_flag sfn_flag_properties #(.W(W), .PW(PW)) u_props (.CLK(CLK), .RST_B(RST_B), .BLANK_B(BLANK_B),
	.TRANSFER_OR_HALF_BYTE_FLAG(TRANSFER_OR_HALF_BYTE_FLAG), .GEN_CTRL(GEN_CTRL), .SHIFT_DIV(SHIFT_DIV),
	.VIDEO_DIV(VIDEO_DIV), .PIX_IN(PIX_IN), .PIX_OUT(PIX_OUT), .SHIFT_CLK(SHIFT_CLK),
	.VIDEO_CLOCK_OUTPUT(VIDEO_CLOCK_OUTPUT), .PIX_VALID(PIX_VALID), .HALF_SEL(HALF_SEL), .MODE_BAD(MODE_BAD));
`default_nettype wire

/* testbench/sfn_gp_model.sv */
`default_nettype none
module sfn_gp_model (
	input  wire logic        lclk, req, nib, split,
	output var  logic        flag,
	output var  logic [31:0] pix
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] hold_q = 3'h0;
	// Fixed word, so every nibble position is distinct
	assign pix = 32'hA5C396E1;
	assign flag = split ? (hold_q != 3'h0) : nib;
	// Flag held four link clocks; no retrigger until it has dropped
	always @(posedge lclk) begin
		if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end else if (req) begin
			hold_q <= 3'h4;
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        CLK = 0, RST_B = 0, BLANK_B = 0, LCLK = 0, req = 0, nib = 0, split = 0;
	logic [3:2]  gen = 2'h0;
	logic [3:0]  sdiv = 4'h4;
	logic [3:0]  vdiv = 4'h8;
	logic [31:0] pix, pout;
	logic        flag, sclk, video_clock_output, valid, half, bad;
	int          num_errors = 0, compares = 0, ns, nv, t;
	always #20 CLK = ~CLK;
	initial #7 forever #160 LCLK = ~LCLK;
	sfn_gp_model gp (.lclk(LCLK), .req(req), .nib(nib), .split(split), .flag(flag), .pix(pix));
	sfn_flag uut (.CLK(CLK), .RST_B(RST_B), .GEN_CTRL(gen), .SHIFT_DIV(sdiv), .VIDEO_DIV(vdiv),
		.BLANK_B(BLANK_B), .TRANSFER_OR_HALF_BYTE_FLAG(flag), .PIX_IN(pix), .SHIFT_CLK(sclk),
		.VIDEO_CLOCK_OUTPUT(video_clock_output), .PIX_OUT(pout), .PIX_VALID(valid), .HALF_SEL(half), .MODE_BAD(bad));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Counts rising edges of both clocks, sampled away from the active edge
	task automatic run(input int n);
		logic s, v;
		ns = 0;
		nv = 0;
		repeat (n) begin
			s = sclk;
			v = video_clock_output;
			@(negedge CLK);
			ns += int'(sclk & ~s);
			nv += int'(video_clock_output & ~v);
		end
	endtask
	// Ratios change just after a fall, so no running high phase is cut or stretched
	task automatic t_div(input logic [3:0] d, input logic [3:0] v);
		BLANK_B = 1;
		for (int i = 0; i < 20 && video_clock_output !== 1'b1; i++) @(negedge CLK);
		for (int i = 0; i < 20 && video_clock_output !== 1'b0; i++) @(negedge CLK);
		vdiv = v;
		for (int i = 0; i < 20 && sclk !== 1'b1; i++) @(negedge CLK);
		for (int i = 0; i < 20 && sclk !== 1'b0; i++) @(negedge CLK);
		sdiv = d;
		run(24);
		run(48);
		chk(ns, 48 / d);
		chk(nv, 48 / v);
	endtask
	task automatic t_off();
		BLANK_B = 0;
		run(16);
		nib = 1;
		run(40);
		chk(ns, 0);
		chk(sclk, 1'b0);
		nib = 0;
		gen = 2'b11;
		@(negedge CLK);
		chk(bad, 1);
		gen = 2'b00;
	endtask
	task automatic t_split();
		gen = 2'b01;
		split = 1;
		run(16);
		req = 1;
		run(10);
		t = ns;
		req = 0;
		run(60);
		chk(t + ns, 1);
		split = 0;
		run(8);
	endtask
	task automatic t_nib(input logic n, input logic [31:0] exp);
		gen = 2'b10;
		BLANK_B = 1;
		nib = n;
		run(40);
		for (int i = 0; i < 20 && valid !== 1'b1; i++) @(negedge CLK);
		chk(valid, 1'b1);
		chk(pout, exp);
		chk(half, n);
	endtask
	initial begin
		repeat (16) @(negedge CLK);
		RST_B = 1;
		t_div(4'h4, 4'h8);
		t_div(4'h6, 4'h4);
		t_off();
		t_split();
		t_nib(1'b1, 32'h0A0C090E);
		t_nib(1'b0, 32'h05030601);
		report_and_stop();
	end
	// Whole run is near 16 us
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
	task automatic report_and_stop();
		if (num_errors == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
endmodule
`default_nettype wire
